// [rtl/dl_framer_regs.svh]
// Frame constants and length limit of the program download framer
`ifndef DL_FRAMER_REGS_SVH
`define DL_FRAMER_REGS_SVH
`define START_CODE_VAL 8'h02
`define FRAME_KIND_VAL 16'h0100
`define CMD_DL_REQ 8'h00
`define CMD_DL_RSP 8'h80
`define CMD_DONE_NTF 8'h01
`define CMD_DONE_RSP 8'h81
`define SEQ_FIRST 8'h01
`define SEQ_LAST 8'hff
`define SEQ_FIXED 8'h00
`define REQ_LEN 16'h0012
`define REQ_SEG_INFO 16'h0000
`define SW_BLANK 8'hff
`define RX_MAX_LEN 16'h0100
`endif

// [rtl/dl_framer_pkg.sv]
// Types shared by the program download framer
package dl_framer_pkg;
    typedef struct packed {
        logic [23:0] maker;
        logic [15:0] model;
        logic [15:0] kind;
    } target_desc_t;
    typedef struct packed {
        logic [23:0] maker;
        logic [47:0] prog_id;
    } sw_desc_t;
    typedef struct packed {
        logic [7:0] data;
        logic last;
    } byte_beat_t;
    typedef struct packed {
        logic [7:0] command_code;
        logic [7:0] frame_seq;
        logic [15:0] payload_length;
    } rx_head_t;
endpackage

// [rtl/dl_frame_tx.sv]
// Byte serialiser for outbound download frames
`timescale 1ns/10ps
`include "dl_framer_regs.svh"
module dl_frame_tx
    import dl_framer_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Frame request
    input wire logic start,
    input wire logic [7:0] command_code,
    input wire logic [7:0] frame_seq,
    input wire logic [15:0] payload_length,
    output logic busy,
    // Payload source, indexed by byte number
    output logic [15:0] pay_idx,
    input wire logic [7:0] pay_byte,
    // Byte stream out
    output byte_beat_t tx_beat,
    output logic tx_valid,
    input wire logic tx_ready
);
    typedef enum logic [2:0] {S_IDLE, S_HEAD, S_PAY, S_CHECK} tx_state_t;
    tx_state_t state_ff, nxt_state;
    logic [2:0] hidx_ff, nxt_hidx;
    logic [15:0] pidx_ff, nxt_pidx;
    logic [7:0] sum_ff, nxt_sum;
    logic [7:0] cmd_ff, nxt_cmd, seq_ff, nxt_seq;
    logic [15:0] len_ff, nxt_len;
    logic [7:0] cur;

    // Header byte for a given position
    function automatic logic [7:0] head_byte(input logic [2:0] i, input logic [7:0] c,
                                             input logic [7:0] s, input logic [15:0] l);
        unique case (i)
            3'd0: head_byte = `START_CODE_VAL;
            3'd1: head_byte = 8'(`FRAME_KIND_VAL >> 8);
            3'd2: head_byte = 8'(`FRAME_KIND_VAL & 16'h00ff);
            3'd3: head_byte = c;
            3'd4: head_byte = s;
            3'd5: head_byte = l[15:8];
            3'd6: head_byte = l[7:0];
            default: head_byte = 8'h00;
        endcase
    endfunction

    assign pay_idx = pidx_ff;
    assign busy = (state_ff != S_IDLE);
    assign tx_valid = busy;

    // Current byte and next state
    always_comb begin
        nxt_state = state_ff;
        nxt_hidx = hidx_ff;
        nxt_pidx = pidx_ff;
        nxt_sum = sum_ff;
        nxt_cmd = cmd_ff;
        nxt_seq = seq_ff;
        nxt_len = len_ff;
        cur = 8'h00;
        unique case (state_ff)
            S_IDLE: begin
                if (start) begin
                    nxt_state = S_HEAD;
                    nxt_hidx = 3'd0;
                    nxt_pidx = 16'h0000;
                    nxt_sum = 8'h00;
                    nxt_cmd = command_code;
                    nxt_seq = frame_seq;
                    nxt_len = payload_length;
                end
            end
            S_HEAD: begin
                cur = head_byte(hidx_ff, cmd_ff, seq_ff, len_ff);
                if (tx_ready) begin
                    if (hidx_ff != 3'd0) begin
                        nxt_sum = sum_ff + cur;
                    end
                    nxt_hidx = hidx_ff + 3'd1;
                    if (hidx_ff == 3'd6) begin
                        nxt_state = (len_ff == 16'h0000) ? S_CHECK : S_PAY;
                    end
                end
            end
            S_PAY: begin
                cur = pay_byte;
                if (tx_ready) begin
                    nxt_sum = sum_ff + cur;
                    nxt_pidx = pidx_ff + 16'h0001;
                    if (pidx_ff == len_ff - 16'h0001) begin
                        nxt_state = S_CHECK;
                    end
                end
            end
            S_CHECK: begin
                cur = 8'h00 - sum_ff;
                if (tx_ready) begin
                    nxt_state = S_IDLE;
                end
            end
            default: nxt_state = S_IDLE;
        endcase
    end

    // Byte data is combinational against the registered state
    always_comb begin
        tx_beat.data = cur;
        tx_beat.last = (state_ff == S_CHECK);
    end

    // State registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= S_IDLE;
            hidx_ff <= 3'd0;
            pidx_ff <= 16'h0000;
            sum_ff <= 8'h00;
            cmd_ff <= 8'h00;
            seq_ff <= 8'h00;
            len_ff <= 16'h0000;
        end else begin
            state_ff <= nxt_state;
            hidx_ff <= nxt_hidx;
            pidx_ff <= nxt_pidx;
            sum_ff <= nxt_sum;
            cmd_ff <= nxt_cmd;
            seq_ff <= nxt_seq;
            len_ff <= nxt_len;
        end
    end

    a_check_last: assert property (@(posedge clk_sys) disable iff (!resetn)
        tx_valid && tx_ready && state_ff == S_CHECK |=> !busy)
        else $error("frame did not end after check byte");
    a_start_first: assert property (@(posedge clk_sys) disable iff (!resetn)
        !busy && start |=> tx_beat.data == `START_CODE_VAL)
        else $error("frame not opened by start code");
endmodule // dl_frame_tx

// [rtl/dl_frame_rx.sv]
// Byte parser for inbound download frames
`timescale 1ns/10ps
`include "dl_framer_regs.svh"
module dl_frame_rx
    import dl_framer_pkg::*;
#(
    parameter logic [15:0] MAX_LEN = `RX_MAX_LEN
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Byte stream in, one byte per valid cycle
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    // Payload bytes as they arrive
    output logic pay_valid,
    output logic [7:0] pay_data,
    output logic [15:0] pay_idx,
    // Frame verdict
    output rx_head_t head,
    output logic frame_ok,
    output logic frame_bad
);
    typedef enum logic [2:0] {R_HUNT, R_HEAD, R_PAY, R_CHECK} rx_state_t;
    rx_state_t state_ff, nxt_state;
    logic [2:0] hidx_ff, nxt_hidx;
    logic [15:0] pidx_ff, nxt_pidx;
    logic [7:0] sum_ff, nxt_sum;
    logic kind_bad_ff, nxt_kind_bad;
    rx_head_t head_ff, nxt_head;
    logic ok_ff, nxt_ok, bad_ff, nxt_bad, pv_ff, nxt_pv;
    logic [7:0] pd_ff, nxt_pd;

    assign head = head_ff;
    assign frame_ok = ok_ff;
    assign frame_bad = bad_ff;
    assign pay_valid = pv_ff;
    assign pay_data = pd_ff;
    assign pay_idx = pidx_ff - 16'h0001;

    // Field tracking, sum and verdict
    always_comb begin
        nxt_state = state_ff;
        nxt_hidx = hidx_ff;
        nxt_pidx = pidx_ff;
        nxt_sum = sum_ff;
        nxt_kind_bad = kind_bad_ff;
        nxt_head = head_ff;
        nxt_ok = 1'b0;
        nxt_bad = 1'b0;
        nxt_pv = 1'b0;
        nxt_pd = pd_ff;
        if (rx_valid) begin
            unique case (state_ff)
                R_HUNT: begin
                    if (rx_byte == `START_CODE_VAL) begin
                        nxt_state = R_HEAD;
                        nxt_hidx = 3'd1;
                        nxt_sum = 8'h00;
                        nxt_kind_bad = 1'b0;
                        nxt_pidx = 16'h0000;
                    end
                end
                R_HEAD: begin
                    nxt_sum = sum_ff + rx_byte;
                    nxt_hidx = hidx_ff + 3'd1;
                    unique case (hidx_ff)
                        3'd1: nxt_kind_bad = (rx_byte != (`FRAME_KIND_VAL >> 8));
                        3'd2: nxt_kind_bad = kind_bad_ff
                                | (rx_byte != (`FRAME_KIND_VAL & 16'h00ff));
                        3'd3: nxt_head.command_code = rx_byte;
                        3'd4: nxt_head.frame_seq = rx_byte;
                        3'd5: nxt_head.payload_length[15:8] = rx_byte;
                        default: nxt_head.payload_length[7:0] = rx_byte;
                    endcase
                    if (hidx_ff == 3'd6) begin
                        if (kind_bad_ff || {head_ff.payload_length[15:8], rx_byte} > MAX_LEN) begin
                            nxt_bad = 1'b1;
                            nxt_state = R_HUNT;
                        end else begin
                            nxt_state = ({head_ff.payload_length[15:8], rx_byte} == 16'h0000)
                                        ? R_CHECK : R_PAY;
                        end
                    end
                end
                R_PAY: begin
                    nxt_sum = sum_ff + rx_byte;
                    nxt_pv = 1'b1;
                    nxt_pd = rx_byte;
                    nxt_pidx = pidx_ff + 16'h0001;
                    if (pidx_ff == head_ff.payload_length - 16'h0001) begin
                        nxt_state = R_CHECK;
                    end
                end
                R_CHECK: begin
                    nxt_state = R_HUNT;
                    if (sum_ff + rx_byte == 8'h00) begin
                        nxt_ok = 1'b1;
                    end else begin
                        nxt_bad = 1'b1;
                    end
                end
                default: nxt_state = R_HUNT;
            endcase
        end
    end

    // State registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            state_ff <= R_HUNT;
            hidx_ff <= 3'd0;
            pidx_ff <= 16'h0000;
            sum_ff <= 8'h00;
            kind_bad_ff <= 1'b0;
            head_ff <= '0;
            ok_ff <= 1'b0;
            bad_ff <= 1'b0;
            pv_ff <= 1'b0;
            pd_ff <= 8'h00;
        end else begin
            state_ff <= nxt_state;
            hidx_ff <= nxt_hidx;
            pidx_ff <= nxt_pidx;
            sum_ff <= nxt_sum;
            kind_bad_ff <= nxt_kind_bad;
            head_ff <= nxt_head;
            ok_ff <= nxt_ok;
            bad_ff <= nxt_bad;
            pv_ff <= nxt_pv;
            pd_ff <= nxt_pd;
        end
    end

    a_verdict_excl: assert property (@(posedge clk_sys) disable iff (!resetn)
        !(frame_ok && frame_bad))
        else $error("frame both good and bad");
    a_bad_sum: assert property (@(posedge clk_sys) disable iff (!resetn)
        rx_valid && state_ff == R_CHECK && (sum_ff + rx_byte) != 8'h00 |=> frame_bad)
        else $error("bad check byte accepted");
endmodule // dl_frame_rx

// [rtl/dl_framer.sv]
// Program download framer on the adapter side: request builder and response parser
`timescale 1ns/10ps
`include "dl_framer_regs.svh"
module dl_framer
    import dl_framer_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Request side from the adapter controller
    input wire logic req_send,
    input wire logic req_done,
    input wire logic [15:0] req_segment,
    input wire target_desc_t target,
    input wire logic prog_stored,
    input wire sw_desc_t stored_sw,
    output logic req_busy,
    // Serial byte stream toward the appliance
    output byte_beat_t tx_beat,
    output logic tx_valid,
    input wire logic tx_ready,
    // Serial byte stream from the appliance
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    // Parsed responses
    output logic rsp_valid,
    output logic [7:0] rsp_command,
    output logic [15:0] rsp_length,
    output logic rsp_seq_match,
    output logic pay_valid,
    output logic [7:0] pay_data,
    output logic [15:0] pay_idx,
    output logic frame_drop
);
    logic [7:0] seq_ff, nxt_seq;
    logic [7:0] last_seq_ff, nxt_last_seq;
    logic [7:0] cmd_ff, nxt_cmd;
    logic [15:0] seg_ff, nxt_seg;
    target_desc_t tgt_ff, nxt_tgt;
    sw_desc_t sw_ff, nxt_sw;
    logic start;
    logic [15:0] len;
    logic [15:0] tx_idx;
    logic [7:0] pay_byte;
    logic [143:0] req_image;
    rx_head_t head;
    logic ok, bad;
    logic rsp_valid_ff, nxt_rsp_valid;
    logic [7:0] rsp_cmd_ff, nxt_rsp_cmd;
    logic [15:0] rsp_len_ff, nxt_rsp_len;
    logic match_ff, nxt_match;
    logic drop_ff, nxt_drop;

    // Only request and completion notification are ever sent
    assign start = (req_send || req_done) && !req_busy;
    // Length follows the command being captured, so it is right at the start edge
    assign len = (nxt_cmd == `CMD_DL_REQ) ? `REQ_LEN : 16'h0001;

    // Capture request fields; sequence wraps 0xff back to 0x01
    always_comb begin
        nxt_seq = seq_ff;
        nxt_last_seq = last_seq_ff;
        nxt_cmd = cmd_ff;
        nxt_seg = seg_ff;
        nxt_tgt = tgt_ff;
        nxt_sw = sw_ff;
        if (start) begin
            nxt_cmd = req_send ? `CMD_DL_REQ : `CMD_DONE_NTF;
            nxt_seg = req_segment;
            nxt_tgt = target;
            nxt_sw = prog_stored ? stored_sw : {9{`SW_BLANK}};
            nxt_last_seq = seq_ff;
            nxt_seq = (seq_ff == `SEQ_LAST) ? `SEQ_FIRST : seq_ff + 8'h01;
        end
    end

    // Payload image, most significant byte first
    assign req_image = {seg_ff, tgt_ff, sw_ff};

    // Select payload byte; completion notification carries one byte
    always_comb begin
        pay_byte = 8'h00;
        if (cmd_ff == `CMD_DL_REQ) begin
            if (tx_idx < `REQ_LEN) begin
                pay_byte = req_image[143 - 8 * tx_idx[4:0] -: 8];
            end
        end else begin
            pay_byte = seg_ff[7:0];
        end
    end

    // Request field registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            seq_ff <= `SEQ_FIRST;
            last_seq_ff <= 8'h00;
            cmd_ff <= 8'h00;
            seg_ff <= 16'h0000;
            tgt_ff <= '0;
            sw_ff <= '0;
        end else begin
            seq_ff <= nxt_seq;
            last_seq_ff <= nxt_last_seq;
            cmd_ff <= nxt_cmd;
            seg_ff <= nxt_seg;
            tgt_ff <= nxt_tgt;
            sw_ff <= nxt_sw;
        end
    end

    // Outbound serialiser
    dl_frame_tx u_tx (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .start(start),
        .command_code(nxt_cmd),
        .frame_seq(seq_ff),
        .payload_length(len),
        .busy(req_busy),
        .pay_idx(tx_idx),
        .pay_byte(pay_byte),
        .tx_beat(tx_beat),
        .tx_valid(tx_valid),
        .tx_ready(tx_ready)
    );

    // Inbound parser
    dl_frame_rx u_rx (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .rx_byte(rx_byte),
        .rx_valid(rx_valid),
        .pay_valid(pay_valid),
        .pay_data(pay_data),
        .pay_idx(pay_idx),
        .head(head),
        .frame_ok(ok),
        .frame_bad(bad)
    );

    // Response verdict: only response codes are acted on
    always_comb begin
        nxt_rsp_valid = 1'b0;
        nxt_rsp_cmd = rsp_cmd_ff;
        nxt_rsp_len = rsp_len_ff;
        nxt_match = match_ff;
        nxt_drop = bad;
        if (ok) begin
            if (head.command_code == `CMD_DL_RSP || head.command_code == `CMD_DONE_RSP) begin
                nxt_rsp_valid = 1'b1;
                nxt_rsp_cmd = head.command_code;
                nxt_rsp_len = head.payload_length;
                nxt_match = (head.frame_seq == last_seq_ff)
                            || (head.frame_seq == `SEQ_FIXED);
            end else begin
                nxt_drop = 1'b1;
            end
        end
    end

    // Response registers
    always_ff @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            rsp_valid_ff <= 1'b0;
            rsp_cmd_ff <= 8'h00;
            rsp_len_ff <= 16'h0000;
            match_ff <= 1'b0;
            drop_ff <= 1'b0;
        end else begin
            rsp_valid_ff <= nxt_rsp_valid;
            rsp_cmd_ff <= nxt_rsp_cmd;
            rsp_len_ff <= nxt_rsp_len;
            match_ff <= nxt_match;
            drop_ff <= nxt_drop;
        end
    end

    assign rsp_valid = rsp_valid_ff;
    assign rsp_command = rsp_cmd_ff;
    assign rsp_length = rsp_len_ff;
    assign rsp_seq_match = match_ff;
    assign frame_drop = drop_ff;

    a_seq_range: assert property (@(posedge clk_sys) disable iff (!resetn)
        seq_ff != 8'h00)
        else $error("sequence left its range");
    a_seq_step: assert property (@(posedge clk_sys) disable iff (!resetn)
        start |=> seq_ff == (($past(seq_ff) == 8'hff) ? 8'h01 : $past(seq_ff) + 8'h01))
        else $error("sequence did not step");
    a_cmd_legal: assert property (@(posedge clk_sys) disable iff (!resetn)
        req_busy |-> cmd_ff == `CMD_DL_REQ || cmd_ff == `CMD_DONE_NTF)
        else $error("reserved command sent");
    a_blank_sw: assert property (@(posedge clk_sys) disable iff (!resetn)
        start && req_send && !prog_stored |=> sw_ff == {9{8'hff}})
        else $error("blank descriptor not all ones");
    a_drop_quiet: assert property (@(posedge clk_sys) disable iff (!resetn)
        bad |=> frame_drop && !rsp_valid)
        else $error("bad frame acted on");
    c_request: cover property (@(posedge clk_sys) disable iff (!resetn) start && req_send);
    c_done: cover property (@(posedge clk_sys) disable iff (!resetn) start && req_done);
    c_rsp: cover property (@(posedge clk_sys) disable iff (!resetn) rsp_valid && rsp_seq_match);
    c_drop: cover property (@(posedge clk_sys) disable iff (!resetn) frame_drop);
endmodule // dl_framer

// [bench/dl_appliance_model.sv]
// Appliance-side model that answers download frames from the framer
`timescale 1ns/10ps
module dl_appliance_model
    import dl_framer_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic resetn,
    // Stream from the framer
    input wire byte_beat_t tx_beat,
    input wire logic tx_valid,
    output logic tx_ready,
    // Stream back to the framer
    output logic [7:0] rx_byte,
    output logic rx_valid,
    // Behaviour knobs
    input wire logic slow,
    input wire logic fixed_seq,
    input wire logic bad_chk
);
    logic [7:0] got[64];
    int n_got;
    logic done;
    logic [7:0] q[$];
    logic [7:0] sum;
    int n;
    // Capture one request, then answer it a byte per cycle
    always @(posedge clk_sys or negedge resetn) begin
        if (!resetn) begin
            tx_ready <= 1'b0;
            rx_valid <= 1'b0;
            rx_byte <= 8'h00;
            n_got = 0;
            done = 1'b0;
        end else begin
            // Idle line alternates between the last byte and its complement
            rx_valid <= q.size() > 0;
            rx_byte <= (q.size() > 0) ? q.pop_front() : ~rx_byte;
            tx_ready <= slow ? ~tx_ready : 1'b1;
            if (tx_valid && tx_ready) begin
                if (done) n_got = 0;
                got[n_got] = tx_beat.data;
                n_got++;
                done = tx_beat.last;
                if (tx_beat.last) begin
                    q = '{8'h01, 8'h00, got[3] | 8'h80, fixed_seq ? 8'h00 : got[4]};
                    n = (got[3] == 8'h01) ? 1 : ({got[7], got[8]} == 16'h0000) ? 14 : 4;
                    q.push_back(8'h00);
                    q.push_back(n[7:0]);
                    for (int i = 0; i < n; i++)
                        q.push_back(i < 2 ? got[7 + i] : 8'(i));
                    sum = 8'h00;
                    foreach (q[k]) sum += q[k];
                    q.push_front(8'h02);
                    // A corrupt check byte is sent only when the bench asks
                    q.push_back(-sum ^ {7'h00, bad_chk});
                end
            end
        end
    end
endmodule // dl_appliance_model

// [bench/tb.sv]
// Self-checking bench for the download framer against the appliance model
`timescale 1ns/10ps
`include "dl_framer_regs.svh"
module tb;
    import dl_framer_pkg::*;
    logic clk_sys, resetn, req_send, req_done, prog_stored, tx_ready, rx_valid;
    logic req_busy, tx_valid, rsp_valid, rsp_seq_match, pay_valid, frame_drop;
    logic [15:0] req_segment, rsp_length, pay_idx;
    logic [7:0] rx_byte, rsp_command, pay_data, exp_seq;
    logic [7:0] exp[$];
    target_desc_t target;
    sw_desc_t stored_sw;
    byte_beat_t tx_beat;
    logic slow, fixed_seq, bad_chk;
    int mismatches, n_checks;
    // Free-running system clock
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    dl_framer i_dut (.clk_sys(clk_sys), .resetn(resetn), .req_send(req_send),
        .req_done(req_done), .req_segment(req_segment), .target(target),
        .prog_stored(prog_stored), .stored_sw(stored_sw), .req_busy(req_busy),
        .tx_beat(tx_beat), .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte),
        .rx_valid(rx_valid), .rsp_valid(rsp_valid), .rsp_command(rsp_command),
        .rsp_length(rsp_length), .rsp_seq_match(rsp_seq_match), .pay_valid(pay_valid),
        .pay_data(pay_data), .pay_idx(pay_idx), .frame_drop(frame_drop));
    dl_appliance_model i_app (.clk_sys(clk_sys), .resetn(resetn), .tx_beat(tx_beat),
        .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_byte(rx_byte), .rx_valid(rx_valid),
        .slow(slow), .fixed_seq(fixed_seq), .bad_chk(bad_chk));
    task automatic chk(input string what, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic end_of_test();
        $display("Checks %0d mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // One request or notification, judged byte by byte and by its answer
    task automatic run(input logic is_done, input logic [15:0] seg, input logic drop);
        int k;
        logic [7:0] sum;
        logic [71:0] sw;
        // Let knobs set by the scenario settle before building the expectation
        @(posedge clk_sys);
        exp = '{8'h01, 8'h00, is_done ? `CMD_DONE_NTF : `CMD_DL_REQ, exp_seq, 8'h00,
            is_done ? 8'h01 : 8'h12};
        sw = prog_stored ? stored_sw : {9{`SW_BLANK}};
        if (is_done) begin
            exp.push_back(seg[7:0]);
        end else begin
            exp.push_back(seg[15:8]);
            exp.push_back(seg[7:0]);
            for (k = 6; k >= 0; k--) exp.push_back(target[8 * k +: 8]);
            for (k = 8; k >= 0; k--) exp.push_back(sw[8 * k +: 8]);
        end
        sum = 8'h00;
        foreach (exp[i]) sum += exp[i];
        exp.push_front(`START_CODE_VAL);
        exp.push_back(-sum);
        req_segment <= seg;
        req_send <= !is_done;
        req_done <= is_done;
        @(posedge clk_sys);
        req_send <= 1'b0;
        req_done <= 1'b0;
        k = 0;
        while (k < 400 && rsp_valid !== 1'b1 && frame_drop !== 1'b1) begin
            @(posedge clk_sys);
            #1;
            k++;
        end
        if (k == 400) begin
            mismatches++;
            end_of_test();
        end
        chk("frame size", 16'(exp.size()), 16'(i_app.n_got));
        foreach (exp[i]) chk("tx byte", exp[i], i_app.got[i]);
        chk("drop", drop, frame_drop);
        if (!drop) begin
            chk("rsp cmd", is_done ? `CMD_DONE_RSP : `CMD_DL_RSP, rsp_command);
            chk("seq match", 1'b1, rsp_seq_match);
            chk("rsp len", is_done ? 1 : (seg == 0 ? 14 : 4), rsp_length);
            chk("pay data", is_done ? seg[7:0] : (seg == 0 ? 8'h0d : 8'h03), pay_data);
            chk("pay idx", is_done ? 16'h0000 : (seg == 0 ? 16'h000d : 16'h0003), pay_idx);
        end
        exp_seq = (exp_seq == `SEQ_LAST) ? `SEQ_FIRST : exp_seq + 8'h01;
        repeat (2) @(posedge clk_sys);
    endtask
    task automatic sc_info_blank();
        prog_stored <= 1'b0;
        run(1'b0, `REQ_SEG_INFO, 1'b0);
    endtask
    task automatic sc_segment_slow();
        prog_stored <= 1'b1;
        slow <= 1'b1;
        run(1'b0, 16'h0102, 1'b0);
        slow <= 1'b0;
    endtask
    task automatic sc_notify();
        run(1'b1, 16'h00a7, 1'b0);
    endtask
    task automatic sc_fixed_seq();
        fixed_seq <= 1'b1;
        run(1'b0, 16'h0001, 1'b0);
        fixed_seq <= 1'b0;
    endtask
    task automatic sc_bad_check();
        bad_chk <= 1'b1;
        run(1'b0, 16'h0003, 1'b1);
        bad_chk <= 1'b0;
    endtask
    // Enough frames to carry the sequence across its wrap
    task automatic sc_seq_wrap();
        for (int i = 0; i < 256; i++)
            run(i[0], 16'(i + 1), 1'b0);
    endtask
    // Watchdog against a hang
    initial begin
        #2ms;
        mismatches++;
        end_of_test();
    end
    initial begin
        resetn = 1'b0;
        req_send = 1'b0;
        req_done = 1'b0;
        req_segment = 16'h0000;
        prog_stored = 1'b0;
        target = 56'h112233_4455_6677;
        stored_sw = 72'ha1a2a3_b1b2b3b4b5b6;
        slow = 1'b0;
        fixed_seq = 1'b0;
        bad_chk = 1'b0;
        exp_seq = `SEQ_FIRST;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        sc_info_blank();
        sc_segment_slow();
        sc_notify();
        sc_fixed_seq();
        sc_bad_check();
        sc_seq_wrap();
        end_of_test();
    end
endmodule // tb
